// [shared/dual_fetch_pkg.sv]
// Shared constants and types for the dual-fetch compute decoder
`default_nettype none
package dual_fetch_pkg;

   // Widths
   localparam int DATA_W = 16;
   localparam int ADDR_W = 14;
   localparam int MR_W   = 40;
   localparam int WORD_W = 24;
   localparam int PADDR_W = 12;

   // Register byte offsets on APB
   localparam logic [11:0] OFS_STATUS = 12'h000; // arithmetic_status
   localparam logic [11:0] OFS_DECODE = 12'h004; // last decode summary
   localparam logic [11:0] OFS_WORD   = 12'h008; // last instruction word
   localparam logic [11:0] OFS_XOPS   = 12'h010; // x operands, 4 words
   localparam logic [11:0] OFS_YOPS   = 12'h020; // y operands, 4 words
   localparam logic [11:0] OFS_ALURES = 12'h030; // alu_result_register
   localparam logic [11:0] OFS_MRLO   = 12'h034; // mult result bits 31:0
   localparam logic [11:0] OFS_MRHI   = 12'h038; // mult result bits 39:32
   localparam logic [11:0] OFS_INDEX  = 12'h040; // index regs, 8 words
   localparam logic [11:0] OFS_MODIFY = 12'h060; // modify regs, 8 words
   localparam logic [11:0] OFS_LAST   = 12'h07c;

   // arithmetic_status bit positions and reset value
   localparam int BIT_ZERO   = 0;
   localparam int BIT_NEG    = 1;
   localparam int BIT_OVF    = 2;
   localparam int BIT_CARRY  = 3;
   localparam int BIT_SIGN   = 4;
   localparam int BIT_QUOT   = 5;
   localparam int BIT_MOVF   = 6;
   localparam int BIT_SHSIGN = 7;
   localparam logic [7:0] STATUS_RESET = 8'h00;

   // Decode summary field positions
   localparam int DEC_GEN  = 8;
   localparam int DEC_DIR  = 9;
   localparam int DEC_RES  = 10;
   localparam int DEC_FUNC = 11;
   localparam int DEC_RGP  = 16;

   // Instruction word bit positions for types 2 to 5
   localparam int POS_GEN   = 20;
   localparam int POS_DIR3  = 20;
   localparam int POS_DIR4  = 19;
   localparam int POS_RES   = 18;
   localparam int POS_RGP   = 18;
   localparam int POS_FUNC  = 13;

   // Function code classes
   localparam logic [4:0] FUNC_NOP = 5'h00;
   localparam int         FUNC_ALU_BIT = 4;
   localparam logic [3:0] MAC_MUL  = 4'h1;
   localparam logic [3:0] MAC_ACC  = 4'h2;
   localparam logic [3:0] MAC_SUB  = 4'h3;
   localparam logic [3:0] MAC_CLR  = 4'h4;
   localparam logic [3:0] ALU_ABS  = 4'hf;

   // Dual-fetch word layout, MSB first
   typedef struct packed {
      logic [1:0] opc;
      logic [1:0] pmDest;
      logic [1:0] dmDest;
      logic [4:0] func;
      logic [1:0] yop;
      logic [2:0] xop;
      logic [1:0] pmIdx;
      logic [1:0] pmMod;
      logic [1:0] dmIdx;
      logic [1:0] dmMod;
   } dual_word_type;

   // Instruction class, one-hot
   typedef enum logic [5:0] {
      CLS_DUAL  = 6'b000001,
      CLS_DMIMM = 6'b000010,
      CLS_DMDIR = 6'b000100,
      CLS_CMPDM = 6'b001000,
      CLS_CMPPM = 6'b010000,
      CLS_OTHER = 6'b100000
   } instr_class_type;

endpackage
`default_nettype wire

// [design/dual_fetch_compute_decoder.sv]
// Dual-fetch compute decoder with post-modify address generators
//
// Contract
// - One compute plus DM read plus PM read
// - DM feeds X operands, PM feeds Y
// - DM uses index/modify 0-3, PM 4-7
// - Address with index, then add modify
// - Fetched word lands right-justified
// - Dual-fetch compute is never conditional
// - No divide steps in this form
// - ALU to ALU result, MAC to MAC result
// - Reads at cycle start, writes at end
// - Shared operand: compute old, fetch replaces
// - Flags as single compute; fetches leave flags
// - Zero and negative flags from ALU result
// - Overflow and carry flags from ALU
// - Sign flag changes only on absolute value
// - MAC overflow beyond low 32 result bits
// - Top bits 11 select dual-fetch form
// - Prefix 101 decodes immediate data write
// - Prefix 100 decodes immediate address access
// - Prefix 011 decodes compute with DM access
// - Prefix 0101 decodes compute with PM access
// - Other encodings reserved, no behaviour
// - Function zero: only the two reads
`timescale 1ns/1ps
`default_nettype none
module dual_fetch_compute_decoder
   import dual_fetch_pkg::*;
(
   input  wire logic                mclk,      // 50 MHz clock
   input  wire logic                rst,       // Sync reset, active high
   input  wire logic                instrValid, // Instruction word present
   input  wire logic [WORD_W-1:0]   instrWord, // Instruction word
   output logic                     dmRead,    // Data memory read strobe
   output logic [ADDR_W-1:0]        dmAddr,    // Data memory address
   input  wire logic [DATA_W-1:0]   dmRdData,  // Data memory read word
   output logic                     pmRead,    // Program memory read strobe
   output logic [ADDR_W-1:0]        pmAddr,    // Program memory address
   input  wire logic [DATA_W-1:0]   pmRdData,  // Program memory read word
   output logic [7:0]               statusOut, // arithmetic_status copy
   input  wire logic                psel,      // APB select
   input  wire logic                penable,   // APB enable
   input  wire logic                pwrite,    // APB direction
   input  wire logic [PADDR_W-1:0]  paddr,     // APB byte address
   input  wire logic [31:0]         pwdata,    // APB write data
   output logic [31:0]              prdata,    // APB read data
   output logic                     pready,    // APB ready
   output logic                     pslverr    // APB error
);

   ////////////////////////////////////////////////////////////////////////
   // State
   logic [DATA_W-1:0]   xOp_r [4];   // AX0, AX1, MX0, MX1
   logic [DATA_W-1:0]   yOp_r [4];   // AY0, AY1, MY0, MY1
   logic [DATA_W-1:0]   aluRes_r;
   logic [MR_W-1:0]     macRes_r;
   logic [ADDR_W-1:0]   idx_r [8];
   logic [ADDR_W-1:0]   mod_r [8];
   logic [7:0]          status_r;
   logic [7:0]          status_nxt;
   logic                exec_r;
   dual_word_type       execWord_r;
   logic [ADDR_W-1:0]   dmAddr_r;
   logic [ADDR_W-1:0]   pmAddr_r;
   logic [WORD_W-1:0]   lastWord_r;
   logic [17:0]         decode_r;
   logic [31:0]         prdata_r;
   logic                pready_r;
   logic                pslverr_r;

   dual_word_type       inWord;
   instr_class_type     inClass;
   logic                dualGo;
   logic [ADDR_W-1:0]   dmNextIdx;
   logic [ADDR_W-1:0]   pmNextIdx;

   assign inWord = dual_word_type'(instrWord);

   ////////////////////////////////////////////////////////////////////////
   // Top-level decode
   always_comb begin
      unique casez (instrWord[23:20])
         4'b11??: inClass = CLS_DUAL;
         4'b101?: inClass = CLS_DMIMM;
         4'b100?: inClass = CLS_DMDIR;
         4'b011?: inClass = CLS_CMPDM;
         4'b0101: inClass = CLS_CMPPM;
         default: inClass = CLS_OTHER;
      endcase
   end

   // Only the dual-fetch form acts; it has no condition field
   assign dualGo = instrValid && (inClass == CLS_DUAL);

   // Decode summary of the last accepted word
   always_ff @(posedge mclk) begin
      if (rst) begin
         decode_r   <= '0;
         lastWord_r <= '0;
      end else if (instrValid) begin
         lastWord_r <= instrWord;
         decode_r   <= '0;
         decode_r[5:0] <= inClass;
         unique case (inClass)
            CLS_DMIMM: decode_r[DEC_GEN] <= instrWord[POS_GEN];
            CLS_DMDIR: begin
               decode_r[DEC_DIR] <= instrWord[POS_DIR3];
               decode_r[DEC_RGP+:2] <= instrWord[POS_RGP+:2];
            end
            CLS_CMPDM: begin
               decode_r[DEC_GEN] <= instrWord[POS_GEN];
               decode_r[DEC_DIR] <= instrWord[POS_DIR4];
               decode_r[DEC_RES] <= instrWord[POS_RES];
               decode_r[DEC_FUNC+:5] <= instrWord[POS_FUNC+:5];
            end
            CLS_CMPPM: begin
               decode_r[DEC_DIR] <= instrWord[POS_DIR4];
               decode_r[DEC_RES] <= instrWord[POS_RES];
               decode_r[DEC_FUNC+:5] <= instrWord[POS_FUNC+:5];
            end
            CLS_DUAL:  decode_r[DEC_FUNC+:5] <= inWord.func;
            CLS_OTHER: decode_r[5:0] <= inClass;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Address generators: DM side uses 0-3, PM side 4-7
   assign dmNextIdx = idx_r[{1'b0, inWord.dmIdx}]
                    + mod_r[{1'b0, inWord.dmMod}];
   assign pmNextIdx = idx_r[{1'b1, inWord.pmIdx}]
                    + mod_r[{1'b1, inWord.pmMod}];

   always_ff @(posedge mclk) begin
      if (rst) begin
         dmAddr_r   <= '0;
         pmAddr_r   <= '0;
         exec_r     <= 1'b0;
         execWord_r <= '0;
      end else begin
         exec_r <= dualGo;
         if (dualGo) begin
            dmAddr_r   <= idx_r[{1'b0, inWord.dmIdx}];
            pmAddr_r   <= idx_r[{1'b1, inWord.pmIdx}];
            execWord_r <= inWord;
         end
      end
   end

   // Address generator writes beat APB writes in the same cycle
   logic apbWr;
   assign apbWr = psel && penable && pwrite && pready_r;

   for (genvar k = 0; k < 8; k++) begin : g_dag
      logic [1:0] selIdx;
      logic       postHit;
      assign selIdx  = (k < 4) ? inWord.dmIdx : inWord.pmIdx;
      assign postHit = dualGo && (selIdx == 2'(k % 4));

      always_ff @(posedge mclk) begin
         if (rst) begin
            idx_r[k] <= '0;
         end else if (postHit) begin
            idx_r[k] <= (k < 4) ? dmNextIdx : pmNextIdx;
         end else if (apbWr && paddr == OFS_INDEX + 12'(4 * k)) begin
            idx_r[k] <= pwdata[ADDR_W-1:0];
         end
      end

      always_ff @(posedge mclk) begin
         if (rst) begin
            mod_r[k] <= '0;
         end else if (apbWr && paddr == OFS_MODIFY + 12'(4 * k)) begin
            mod_r[k] <= pwdata[ADDR_W-1:0];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Operand fetch for the executing word (values at cycle start)
   logic              isAlu;
   logic              isMac;
   logic [DATA_W-1:0] xVal;
   logic [DATA_W-1:0] yVal;

   // Every non-zero code is ALU or MAC; divide steps have no code here
   assign isAlu = exec_r && execWord_r.func[FUNC_ALU_BIT];
   assign isMac = exec_r && !execWord_r.func[FUNC_ALU_BIT]
                         && (execWord_r.func != FUNC_NOP);

   always_comb begin
      unique case (execWord_r.xop)
         3'd0:    xVal = isAlu ? xOp_r[0] : xOp_r[2];
         3'd1:    xVal = isAlu ? xOp_r[1] : xOp_r[3];
         3'd2:    xVal = aluRes_r;
         3'd3:    xVal = macRes_r[15:0];
         3'd4:    xVal = macRes_r[31:16];
         3'd5:    xVal = {{8{macRes_r[39]}}, macRes_r[39:32]};
         default: xVal = '0;
      endcase
      unique case (execWord_r.yop)
         2'd0:    yVal = isAlu ? yOp_r[0] : yOp_r[2];
         2'd1:    yVal = isAlu ? yOp_r[1] : yOp_r[3];
         default: yVal = '0;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////
   // ALU: one adder with steered operands, logic ops beside it
   logic [DATA_W-1:0] opA;
   logic [DATA_W-1:0] opB;
   logic              cin;
   logic              useAdd;
   logic [DATA_W-1:0] logicRes;
   logic [DATA_W:0]   sum;
   logic [DATA_W-1:0] aluVal;
   logic              aluCarry;
   logic              aluOvf;

   always_comb begin
      opA      = '0;
      opB      = '0;
      cin      = 1'b0;
      useAdd   = 1'b1;
      logicRes = '0;
      unique case (execWord_r.func[3:0])
         4'h0: opB = yVal;
         4'h1: begin opB = yVal; cin = 1'b1; end
         4'h2: begin opA = xVal; opB = yVal; cin = status_r[BIT_CARRY]; end
         4'h3: begin opA = xVal; opB = yVal; end
         4'h4: begin useAdd = 1'b0; logicRes = ~yVal; end
         4'h5: begin opB = ~yVal; cin = 1'b1; end
         4'h6: begin opA = xVal; opB = ~yVal; cin = status_r[BIT_CARRY]; end
         4'h7: begin opA = xVal; opB = ~yVal; cin = 1'b1; end
         4'h8: begin opA = 16'hffff; opB = yVal; end
         4'h9: begin opA = yVal; opB = ~xVal; cin = 1'b1; end
         4'ha: begin opA = yVal; opB = ~xVal; cin = status_r[BIT_CARRY]; end
         4'hb: begin useAdd = 1'b0; logicRes = ~xVal; end
         4'hc: begin useAdd = 1'b0; logicRes = xVal & yVal; end
         4'hd: begin useAdd = 1'b0; logicRes = xVal | yVal; end
         4'he: begin useAdd = 1'b0; logicRes = xVal ^ yVal; end
         4'hf: begin
            opB = xVal[15] ? ~xVal : xVal;
            cin = xVal[15];
         end
      endcase
      sum      = {1'b0, opA} + {1'b0, opB} + {16'h0000, cin};
      aluVal   = useAdd ? sum[DATA_W-1:0] : logicRes;
      aluCarry = useAdd & sum[DATA_W];
      aluOvf   = useAdd & (opA[15] == opB[15]) & (sum[15] != opA[15]);
   end

   ////////////////////////////////////////////////////////////////////////
   // Multiplier / accumulator
   logic signed [31:0] product;
   logic [MR_W-1:0]    prodExt;
   logic [MR_W-1:0]    macVal;
   logic               macOvf;

   assign product = $signed(xVal) * $signed(yVal);
   assign prodExt = {{(MR_W-32){product[31]}}, product};

   always_comb begin
      unique case (execWord_r.func[3:0])
         MAC_MUL: macVal = prodExt;
         MAC_ACC: macVal = macRes_r + prodExt;
         MAC_SUB: macVal = macRes_r - prodExt;
         MAC_CLR: macVal = '0;
         default: macVal = macRes_r;
      endcase
      macOvf = !((&macVal[39:31]) || !(|macVal[39:31]));
   end

   ////////////////////////////////////////////////////////////////////////
   // Result registers, written at end of cycle
   always_ff @(posedge mclk) begin
      if (rst) begin
         aluRes_r <= '0;
      end else if (isAlu) begin
         aluRes_r <= aluVal;
      end
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         macRes_r <= '0;
      end else if (isMac) begin
         macRes_r <= macVal;
      end
   end

   // Operand loads: both fetches land on the same edge
   for (genvar k = 0; k < 4; k++) begin : g_ops
      always_ff @(posedge mclk) begin
         if (rst) begin
            xOp_r[k] <= '0;
         end else if (exec_r && execWord_r.dmDest == 2'(k)) begin
            xOp_r[k] <= dmRdData;
         end
      end

      always_ff @(posedge mclk) begin
         if (rst) begin
            yOp_r[k] <= '0;
         end else if (exec_r && execWord_r.pmDest == 2'(k)) begin
            yOp_r[k] <= pmRdData;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // arithmetic_status: compute updates win over APB writes per bit
   always_comb begin
      status_nxt = status_r;
      if (apbWr && paddr == OFS_STATUS) begin
         status_nxt = pwdata[7:0];
      end
      if (isAlu) begin
         status_nxt[BIT_ZERO]  = (aluVal == '0);
         status_nxt[BIT_NEG]   = aluVal[15];
         status_nxt[BIT_OVF]   = aluOvf;
         status_nxt[BIT_CARRY] = aluCarry;
         if (execWord_r.func[3:0] == ALU_ABS) begin
            status_nxt[BIT_SIGN] = xVal[15];
         end
      end
      if (isMac) begin
         status_nxt[BIT_MOVF] = macOvf;
      end
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         status_r <= STATUS_RESET;
      end else begin
         status_r <= status_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // APB slave: one wait state, registered answer
   logic [31:0] rdMux;
   logic        mapped;

   always_comb begin
      rdMux  = '0;
      mapped = (paddr[1:0] == 2'b00) && (paddr <= OFS_LAST);
      if (paddr[11:5] == OFS_INDEX[11:5]) begin
         rdMux = {18'h0, idx_r[paddr[4:2]]};
      end else if (paddr[11:5] == OFS_MODIFY[11:5]) begin
         rdMux = {18'h0, mod_r[paddr[4:2]]};
      end else if (paddr[11:4] == OFS_XOPS[11:4]) begin
         rdMux = {16'h0, xOp_r[paddr[3:2]]};
      end else if (paddr[11:4] == OFS_YOPS[11:4]) begin
         rdMux = {16'h0, yOp_r[paddr[3:2]]};
      end else begin
         unique case (paddr)
            OFS_STATUS: rdMux = {24'h0, status_r};
            OFS_DECODE: rdMux = {14'h0, decode_r};
            OFS_WORD:   rdMux = {8'h0, lastWord_r};
            OFS_ALURES: rdMux = {16'h0, aluRes_r};
            OFS_MRLO:   rdMux = macRes_r[31:0];
            OFS_MRHI:   rdMux = {24'h0, macRes_r[39:32]};
            default:    mapped = 1'b0;
         endcase
      end
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         pready_r  <= 1'b0;
         prdata_r  <= '0;
         pslverr_r <= 1'b0;
      end else begin
         pready_r  <= psel && penable && !pready_r;
         pslverr_r <= psel && penable && !pready_r && !mapped;
         prdata_r  <= (psel && penable && !pready_r && !pwrite && mapped)
                      ? rdMux : 32'h0000_0000;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Outputs
   assign dmRead    = exec_r;
   assign pmRead    = exec_r;
   assign dmAddr    = dmAddr_r;
   assign pmAddr    = pmAddr_r;
   assign statusOut = status_r;
   assign prdata    = prdata_r;
   assign pready    = pready_r;
   assign pslverr   = pslverr_r;

endmodule // dual_fetch_compute_decoder
`default_nettype wire

// [tb/dual_fetch_checker.sv]
// Port-level assertions for the dual-fetch compute decoder
`timescale 1ns/1ps
`default_nettype none
module dual_fetch_checker
   import dual_fetch_pkg::*;
(
   input wire logic               mclk,       // Clock
   input wire logic               rst,        // Sync reset
   input wire logic               instrValid, // Word present
   input wire logic [WORD_W-1:0]  instrWord,  // Instruction word
   input wire logic               dmRead,     // DM strobe
   input wire logic [ADDR_W-1:0]  dmAddr,     // DM address
   input wire logic               pmRead,     // PM strobe
   input wire logic               psel,       // APB select
   input wire logic               penable,    // APB enable
   input wire logic [PADDR_W-1:0] paddr,      // APB address
   input wire logic [31:0]        prdata,     // APB read data
   input wire logic               pready,     // APB ready
   input wire logic               pslverr     // APB error
);
   default clocking @(posedge mclk); endclocking
   default disable iff (rst);
   wire logic dual = instrValid && instrWord[23:22] == 2'b11;

   ////////////////////////////////////////////////////////////////////
   a_dual_fetches: assert property (dual |=> dmRead && pmRead)
      else $error("dual word without fetch");
   a_other_quiet: assert property (!dual |=> !dmRead)
      else $error("fetch without dual word");
   a_strobes_pair: assert property (dmRead == pmRead)
      else $error("fetch strobes differ");
   a_addr_hold: assert property (!dual |=> $stable(dmAddr))
      else $error("address moved without word");
   a_apb_wait: assert property (psel && !penable |=> !pready ##1 pready)
      else $error("apb wait state wrong");
   a_ready_pulse: assert property (pready |=> !pready)
      else $error("pready longer than a cycle");
   a_ready_access: assert property (pready |-> psel && penable)
      else $error("pready outside access");
   a_err_qual: assert property (pslverr |-> pready)
      else $error("pslverr without pready");
   a_rdata_idle: assert property (!pready |-> prdata == 32'h0)
      else $error("prdata not zero when idle");
   a_unmapped_err: assert property
      (psel && penable && pready && paddr > OFS_LAST |-> pslverr)
      else $error("unmapped access without error");
   c_dual: cover property (dual ##1 dmRead);
   c_err: cover property (pslverr);
   c_read: cover property (pready && !pslverr && prdata != 32'h0);
endmodule // dual_fetch_checker
`default_nettype wire

// [tb/dual_fetch_memory.sv]
// Data and program memory model answering the fetch strobes
`timescale 1ns/1ps
`default_nettype none
module dual_fetch_memory
   import dual_fetch_pkg::*;
(
   input  wire logic              mclk,     // Clock
   input  wire logic              dmRead,   // DM strobe
   input  wire logic [ADDR_W-1:0] dmAddr,   // DM address
   output logic [DATA_W-1:0]      dmRdData, // DM word
   input  wire logic              pmRead,   // PM strobe
   input  wire logic [ADDR_W-1:0] pmAddr,   // PM address
   output logic [DATA_W-1:0]      pmRdData  // PM word
);
   logic [DATA_W-1:0] junk_r = 16'h0;
   function automatic logic [15:0] dmWord(logic [13:0] a);
      return {a[6:0], a[13:5]} ^ 16'ha5c3;
   endfunction
   function automatic logic [15:0] pmWord(logic [13:0] a);
      return {a, a[1:0]} ^ 16'h3c96;
   endfunction
   // Constant filler while not strobed: junk_r stays zero, so DM reads 0 and PM reads all ones
   always_ff @(posedge mclk) begin
      junk_r <= ~junk_r + 16'h1;
   end
   assign dmRdData = dmRead ? dmWord(dmAddr) : junk_r;
   assign pmRdData = pmRead ? pmWord(pmAddr) : ~junk_r;
endmodule // dual_fetch_memory
`default_nettype wire

// [tb/dual_fetch_compute_decoder_test.sv]
// Self-checking bench for the dual-fetch compute decoder
`timescale 1ns/1ps
`default_nettype none
module dual_fetch_compute_decoder_test import dual_fetch_pkg::*;;
   logic               mclk, rst, instrValid, dmRead, pmRead;
   logic               psel, penable, pwrite, pready, pslverr, errSeen;
   logic [WORD_W-1:0]  instrWord;
   logic [ADDR_W-1:0]  dmAddr, pmAddr;
   logic [DATA_W-1:0]  dmRdData, pmRdData, ar;
   logic [7:0]         statusOut, st;
   logic [PADDR_W-1:0] paddr;
   logic [31:0]        pwdata, prdata, rd;
   logic [13:0]        idx [8];
   logic [13:0]        mdf [8];
   logic [15:0]        xr [4];
   logic [15:0]        yr [4];
   logic [39:0]        mr;
   logic [4:0]         funcs [9] = '{5'h00, 5'h13, 5'h17, 5'h1c,
                                     5'h1f, 5'h01, 5'h02, 5'h03, 5'h04};
   logic [23:0]        ow [5] = '{24'ha12345, 24'h812345, 24'h7d2345,
                                  24'h512345, 24'h412345};
   logic [23:0]        w;
   int                 mismatches, nTests;

   dual_fetch_compute_decoder u_dut (.mclk(mclk), .rst(rst),
      .instrValid(instrValid), .instrWord(instrWord), .dmRead(dmRead),
      .dmAddr(dmAddr), .dmRdData(dmRdData), .pmRead(pmRead),
      .pmAddr(pmAddr), .pmRdData(pmRdData), .statusOut(statusOut),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr));
   dual_fetch_memory u_mem (.mclk(mclk), .dmRead(dmRead),
      .dmAddr(dmAddr), .dmRdData(dmRdData), .pmRead(pmRead),
      .pmAddr(pmAddr), .pmRdData(pmRdData));

   initial begin
      mclk = 1'b0;
      forever #10 mclk = ~mclk;
   end

   ////////////////////////////////////////////////////////////////////
   task automatic print_verdict();
      if (mismatches == 0 && nTests > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   task automatic check(string n, logic [39:0] e, logic [39:0] g);
      nTests++;
      if (g !== e) begin
         mismatches++;
         $display("mismatch %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic apb(logic wr, logic [11:0] a, logic [31:0] d);
      int n;
      @(posedge mclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge mclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge mclk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (pready !== 1'b1) begin
         mismatches++;
         print_verdict();
      end
      rd = prdata;
      errSeen = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic apbRd(logic [11:0] a, logic [31:0] e);
      apb(1'b0, a, 32'h0);
      check($sformatf("reg %h", a), e, rd);
   endtask
   task automatic issue(logic [23:0] v);
      @(posedge mclk);
      instrValid <= 1'b1;
      instrWord <= v;
      @(posedge mclk);
      instrValid <= 1'b0;
      #1;
   endtask
   function automatic logic [39:0] prod(logic [15:0] a, logic [15:0] b);
      return {{24{a[15]}}, a} * {{24{b[15]}}, b};
   endfunction
   task automatic dual(logic [23:0] v);
      dual_word_type f;
      logic [15:0] x, y, yy, dw, pw;
      logic [16:0] s;
      logic        mac, ov;
      f = v;
      issue(v);
      dw = u_mem.dmWord(idx[f.dmIdx]);
      pw = u_mem.pmWord(idx[4+f.pmIdx]);
      check("strobes", 1'b1, dmRead & pmRead);
      check("dmAddr", idx[f.dmIdx], dmAddr);
      check("pmAddr", idx[4+f.pmIdx], pmAddr);
      idx[f.dmIdx] += mdf[f.dmMod];
      idx[4+f.pmIdx] += mdf[4+f.pmMod];
      mac = !f.func[4];
      x = xr[{mac, f.xop[0]}];
      y = yr[{mac, f.yop[0]}];
      if (f.func == 5'h01) mr = prod(x, y);
      if (f.func == 5'h02) mr += prod(x, y);
      if (f.func == 5'h03) mr -= prod(x, y);
      if (f.func == 5'h04) mr = 40'h0;
      if (mac && f.func != FUNC_NOP)
         st[6] = !(&mr[39:31] || !(|mr[39:31]));
      if (!mac) begin
         yy = f.func[2] ? ~y : y;
         s = {1'b0, x} + {1'b0, yy} + {16'h0, f.func[2]};
         ov = x[15] == yy[15] && s[15] != x[15];
         if (f.func[3]) begin
            s = f.func[0] ? {1'b0, x[15] ? -x : x} : {1'b0, x & y};
            ov = f.func[0] && x == 16'h8000;
            if (f.func[0]) st[4] = x[15];
         end
         st[3:0] = {s[16], ov, s[15], s[15:0] == 16'h0};
         ar = s[15:0];
      end
      xr[f.dmDest] = dw;
      yr[f.pmDest] = pw;
      apbRd(OFS_STATUS, {24'h0, st});
      apbRd(OFS_ALURES, {16'h0, ar});
      apbRd(OFS_MRLO, mr[31:0]);
      apbRd(OFS_MRHI, {24'h0, mr[39:32]});
      apbRd(OFS_XOPS + {f.dmDest, 2'b0}, {16'h0, dw});
      apbRd(OFS_YOPS + {f.pmDest, 2'b0}, {16'h0, pw});
   endtask

   ////////////////////////////////////////////////////////////////////
   initial begin
      mismatches = 0;
      nTests = 0;
      rst = 1'b1;
      instrValid = 1'b0;
      instrWord = 24'h0;
      {psel, penable, pwrite, paddr, pwdata} = '0;
      {st, ar, mr} = '0;
      for (int i = 0; i < 4; i++) {xr[i], yr[i]} = 32'h0;
      void'($urandom(32'h74fa));
      repeat (20) @(posedge mclk);
      rst <= 1'b0;
      @(posedge mclk);
      apbRd(OFS_STATUS, 32'h0);
      apb(1'b0, 12'h800, 32'h0);
      check("pslverr", 1'b1, errSeen);
      check("errData", 32'h0, rd);
      w = 24'($urandom);
      st = w[7:0];
      apb(1'b1, OFS_STATUS, {w, st});
      for (int i = 0; i < 8; i++) begin
         idx[i] = 14'($urandom);
         mdf[i] = 14'($urandom);
         apb(1'b1, OFS_INDEX + 12'(4 * i), {18'h0, idx[i]});
         apb(1'b1, OFS_MODIFY + 12'(4 * i), {18'h0, mdf[i]});
      end
      for (int k = 0; k < 40; k++) begin
         w = 24'($urandom);
         w[23:22] = 2'b11;
         w[17:13] = funcs[$urandom % 9];
         w[12] = 1'b0;
         w[10:9] = 2'b00;
         dual(w);
      end
      dual(24'he84000);
      dual(24'hc26000);
      apb(1'b0, OFS_DECODE, 32'h0);
      check("dualClass", 6'h1, rd[5:0]);
      for (int i = 0; i < 8; i++)
         apbRd(OFS_INDEX + 12'(4 * i), {18'h0, idx[i]});
      for (int i = 0; i < 5; i++) begin
         issue(ow[i]);
         check("fetch", 1'b0, dmRead | pmRead);
         apb(1'b0, OFS_DECODE, 32'h0);
         check("class", 6'h2 << i, rd[5:0]);
         if (i == 2) check("fields", 8'h4f, rd[15:8]);
      end
      apbRd(OFS_STATUS, {24'h0, st});
      check("statusOut", st, statusOut);
      print_verdict();
   end
endmodule // dual_fetch_compute_decoder_test

bind dual_fetch_compute_decoder dual_fetch_checker u_chk (.mclk(mclk),
   .rst(rst), .instrValid(instrValid), .instrWord(instrWord),
   .dmRead(dmRead), .dmAddr(dmAddr), .pmRead(pmRead), .psel(psel),
   .penable(penable), .paddr(paddr), .prdata(prdata), .pready(pready),
   .pslverr(pslverr));
`default_nettype wire
